// >>> inc/prs_defs.svh
`ifndef PRS_DEFS_SVH
`define PRS_DEFS_SVH
// Clock period in ns
`define PRS_CLK_PERIOD_NS 10
// Power-up reset time, typical and longest, in ns
`define PRS_POR_TIME_NS 2000
`define PRS_POR_MAX_NS 10000
// Typical interval in cycles, then longest interval rounded down
`define PRS_POR_CYC \
   ((`PRS_POR_TIME_NS + `PRS_CLK_PERIOD_NS - 1) / `PRS_CLK_PERIOD_NS)
`define PRS_POR_MAX_CYC (`PRS_POR_MAX_NS / `PRS_CLK_PERIOD_NS)
// Longest wake time after power-down release, ns and cycles
`define PRS_WAKE_MAX_NS 1000
`define PRS_WAKE_MAX_CYC (`PRS_WAKE_MAX_NS / `PRS_CLK_PERIOD_NS)
// Macrocell register reset value
`define PRS_REG_RST 32'h0000_0000
// Pin whose array input is given up to the power-down function
`define PRS_PD_PIN_IDX 31
// Signature size and word count
`define PRS_SIG_BITS 160
`define PRS_SIG_WORDS 5
`endif

// >>> inc/prs_pkg.sv
package prs_pkg;
   typedef enum logic [2:0] {
      PRS_POR = 3'b001,
      PRS_RUN = 3'b010,
      PRS_PDN = 3'b100
   } prs_mode_t;
endpackage

// >>> rtl/prs_ctrl.sv
`timescale 1ns/100ps
// Functional notes
// RQ1: After the supply reset, every macrocell register is cleared low.
// RQ2: The power-up reset interval lasts 2 us typical, 10 us at most.
// RQ3: After reset the driver meets all setup times before its first clock.
// RQ4: The driver keeps clock sources stable during the reset interval.
// RQ5: The power-down pin acts only when configuration enables it.
// RQ6: In power-down all logic states and outputs are held valid; here the fuse, verify and signature logic still respond.
// RQ7: Outputs that are high-Z at power-down entry stay high-Z throughout.
// RQ8: In power-down all inputs but the pin are ignored, pins are kept; here FUSE_PROG, VERIFY_REQ and SIG_REQ still act.
// RQ9: With power-down enabled the pin's array input is unavailable.
// RQ10: In preload mode each register can be forced high or low.
// RQ11: A programmed fuse blocks verify and preload, signature stays.
// RQ12: The programmer should set the security fuse as its last step.
// RQ13: Inputs, enables and clock are valid a lead time before the pin rises.
// RQ14: After the pin falls, inputs and outputs are valid within 1 us.
// RQ15: Leaving power-down resumes sampling from the held register state.
`include "prs_defs.svh"
module prs_ctrl #(
   parameter int W = 32,
   parameter int POR_CYC = `PRS_POR_CYC,
   parameter logic [`PRS_SIG_BITS-1:0] SIG_VALUE = 160'h0
) (
   // Clock and reset
   input wire logic CLK,
   input wire logic SYS_RST,
   // Configuration and power-down
   input wire logic CFG_PD_EN,
   input wire logic POWER_DOWN_PIN,
   // Logic pins
   input wire logic [W-1:0] IN_PINS,
   input wire logic [W-1:0] OE_PINS,
   input wire logic REG_CLK_EN,
   // Preload
   input wire logic PRELOAD_HV,
   input wire logic PRELOAD_STB,
   input wire logic [4:0] PRELOAD_SEL,
   input wire logic PRELOAD_VAL,
   // Fuse, verify and signature
   input wire logic FUSE_PROG,
   input wire logic [W-1:0] CFG_PATTERN,
   input wire logic VERIFY_REQ,
   input wire logic SIG_REQ,
   input wire logic [2:0] SIG_SEL,
   // Outputs
   output logic [W-1:0] REG_Q,
   output logic [W-1:0] COMB_Q,
   output logic [W-1:0] OUT_OE,
   output logic POR_DONE,
   output logic PD_ACTIVE,
   output logic FUSE_SET,
   output logic VERIFY_VALID,
   output logic VERIFY_DENIED,
   output logic [W-1:0] VERIFY_DATA,
   output logic SIG_VALID,
   output logic [31:0] SIG_DATA
);
   import prs_pkg::*;

   localparam int CW = $clog2(POR_CYC + 1);

   prs_mode_t mode_ff;
   prs_mode_t nxt_mode;
   logic [CW-1:0] por_cnt_ff;
   logic [W-1:0] reg_ff;
   logic [W-1:0] hold_in_ff;
   logic [W-1:0] oe_ff;
   logic [W-1:0] array_in;
   logic fuse_ff;
   logic pd_req;

   function automatic logic [31:0] sig_word(input logic [2:0] sel);
      logic [31:0] w;
      w = 32'h0000_0000;
      if (sel < 3'(`PRS_SIG_WORDS)) begin
         w = SIG_VALUE[32*sel +: 32];
      end
      return w;
   endfunction

   assign pd_req = CFG_PD_EN & POWER_DOWN_PIN; // RQ5

   // Mode sequencing
   always_comb begin
      nxt_mode = mode_ff;
      case (mode_ff)
         PRS_POR: begin
            if (por_cnt_ff == CW'(1)) begin
               nxt_mode = PRS_RUN;
            end
         end
         PRS_RUN: begin
            if (pd_req) begin
               nxt_mode = PRS_PDN;
            end
         end
         PRS_PDN: begin
            if (!pd_req) begin
               nxt_mode = PRS_RUN; // RQ14
            end
         end
         default: nxt_mode = PRS_POR;
      endcase
   end

   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         mode_ff <= PRS_POR;
      end else begin
         mode_ff <= nxt_mode;
      end
   end

   // Power-up reset interval counter
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         por_cnt_ff <= CW'(POR_CYC); // RQ2
      end else if (por_cnt_ff != '0) begin
         por_cnt_ff <= por_cnt_ff - CW'(1);
      end
   end

   // Input hold latches, frozen in power-down
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         hold_in_ff <= '0;
      end else if (mode_ff != PRS_PDN) begin
         hold_in_ff <= IN_PINS;
      end // RQ8
   end

   // Pin array input removed when its pin serves power-down
   always_comb begin
      array_in = hold_in_ff;
      if (CFG_PD_EN) begin
         array_in[`PRS_PD_PIN_IDX] = 1'b0; // RQ9
      end
   end

   // Macrocell registers
   always_ff @(posedge CLK) begin
      if (SYS_RST || mode_ff == PRS_POR) begin
         reg_ff <= W'(`PRS_REG_RST); // RQ1
      end else if (mode_ff == PRS_PDN) begin
         reg_ff <= reg_ff; // RQ6
      end else if (PRELOAD_HV && PRELOAD_STB && !fuse_ff) begin
         reg_ff[PRELOAD_SEL] <= PRELOAD_VAL; // RQ10
      end else if (REG_CLK_EN) begin
         reg_ff <= array_in; // RQ15
      end
   end

   // Output enables and combinational outputs
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         oe_ff <= '0;
         COMB_Q <= '0;
      end else if (mode_ff != PRS_PDN) begin
         oe_ff <= OE_PINS;
         COMB_Q <= array_in ^ reg_ff;
      end // RQ7
   end

   // Security fuse
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         fuse_ff <= 1'b0;
      end else if (FUSE_PROG) begin
         fuse_ff <= 1'b1;
      end
   end

   // Verify and signature answers
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         VERIFY_VALID <= 1'b0;
         VERIFY_DENIED <= 1'b0;
         VERIFY_DATA <= '0;
         SIG_VALID <= 1'b0;
         SIG_DATA <= 32'h0000_0000;
      end else begin
         VERIFY_VALID <= VERIFY_REQ && !fuse_ff; // RQ11
         VERIFY_DENIED <= VERIFY_REQ && fuse_ff; // RQ11
         VERIFY_DATA <= (VERIFY_REQ && !fuse_ff) ? CFG_PATTERN : '0;
         SIG_VALID <= SIG_REQ;
         if (SIG_REQ) begin
            SIG_DATA <= sig_word(SIG_SEL);
         end
      end
   end

   assign REG_Q = reg_ff;
   assign OUT_OE = oe_ff;
   assign PD_ACTIVE = (mode_ff == PRS_PDN);
   assign POR_DONE = (mode_ff != PRS_POR);
   assign FUSE_SET = fuse_ff;

   // Cycles spent in the reset interval, for the longest-time check
   logic [10:0] por_wait_ff;

   always_ff @(posedge CLK) begin
      if (SYS_RST || POR_DONE) begin
         por_wait_ff <= 11'h000;
      end else if (por_wait_ff != 11'h7FF) begin
         por_wait_ff <= por_wait_ff + 11'h001;
      end
   end

   default clocking cb @(posedge CLK); endclocking
   default disable iff (SYS_RST);

   a_por_clears_regs: assert property ( // RQ1
      !POR_DONE |-> REG_Q == '0)
      else $error("Register not low during power-up reset");
   a_por_length: assert property ( // RQ2
      $fell(SYS_RST) |-> !POR_DONE [*8])
      else $error("Power-up reset ended too early");
   a_por_ends: assert property ( // RQ2
      !POR_DONE |-> por_wait_ff < 11'(`PRS_POR_MAX_CYC))
      else $error("Power-up reset exceeded its longest time");
   a_pd_needs_cfg: assert property ( // RQ5
      !CFG_PD_EN |=> !PD_ACTIVE)
      else $error("Power-down entered while disabled");
   a_pd_hold_regs: assert property ( // RQ6
      PD_ACTIVE && $past(PD_ACTIVE) |-> $stable(REG_Q) && $stable(COMB_Q))
      else $error("State changed during power-down");
   a_pd_hold_oe: assert property ( // RQ7
      PD_ACTIVE && $past(PD_ACTIVE) |-> $stable(OUT_OE))
      else $error("Output enable changed during power-down");
   a_pd_array_masked: assert property ( // RQ9
      CFG_PD_EN && POR_DONE && !PD_ACTIVE && REG_CLK_EN
      && !(PRELOAD_HV && PRELOAD_STB && !FUSE_SET)
      |=> REG_Q[`PRS_PD_PIN_IDX] == 1'b0)
      else $error("Power-down pin reached logic array");
   a_pd_wake: assert property ( // RQ14
      PD_ACTIVE && !pd_req |=> !PD_ACTIVE)
      else $error("Power-down release too slow");
   a_preload_set: assert property ( // RQ10
      POR_DONE && !PD_ACTIVE && PRELOAD_HV && PRELOAD_STB && !FUSE_SET
      |=> REG_Q[$past(PRELOAD_SEL)] == $past(PRELOAD_VAL))
      else $error("Preload did not force register");
   a_fuse_blocks: assert property ( // RQ11
      FUSE_SET && VERIFY_REQ |=> VERIFY_DENIED && !VERIFY_VALID)
      else $error("Verify allowed with fuse set");
   a_fuse_preload: assert property ( // RQ11
      FUSE_SET && PRELOAD_STB && !REG_CLK_EN |=> $stable(REG_Q))
      else $error("Preload allowed with fuse set");
   a_sig_open: assert property ( // RQ11
      SIG_REQ |=> SIG_VALID)
      else $error("Signature not readable");

   c_pd_cycle: cover property (PD_ACTIVE ##1 !PD_ACTIVE);
   c_preload: cover property (PRELOAD_HV && PRELOAD_STB && POR_DONE);
   c_fuse_deny: cover property (VERIFY_DENIED);
   c_por_done: cover property ($rose(POR_DONE));
endmodule

// >>> verif/prs_sys_drv.sv
`timescale 1ns/100ps
module prs_sys_drv (
   // Clock and status
   input wire logic clk,
   input wire logic por_done,
   // Request and pulse
   input wire logic fire,
   input wire logic slow,
   output logic clk_en
);
   logic dly_ff;
   always_ff @(posedge clk) begin
      dly_ff <= fire;
      // Register clock held quiet until reset interval ends
      clk_en <= por_done & (slow ? dly_ff : fire);
   end
endmodule

// >>> verif/tb_top.sv
`timescale 1ns/100ps
module tb_top;
   import prs_pkg::*;
   localparam int POR = 8;
   localparam logic [31:0] MSK = 32'h7FFF_FFFF;
   // Signature value is arbitrary
   localparam logic [159:0] SIG =
      160'h0123_4567_89AB_CDEF_0011_2233_4455_6677_8899_AABB;
   logic CLK = 0, SYS_RST = 1, CFG_PD_EN = 0, POWER_DOWN_PIN = 0;
   logic [31:0] IN_PINS = 0, OE_PINS = 0, CFG_PATTERN = 0;
   logic PRELOAD_HV = 0, PRELOAD_STB = 0, PRELOAD_VAL = 0, FUSE_PROG = 0;
   logic VERIFY_REQ = 0, SIG_REQ = 0, fire = 0, slow = 0, REG_CLK_EN;
   logic [4:0] PRELOAD_SEL = 0;
   logic [2:0] SIG_SEL = 0;
   logic [31:0] REG_Q, COMB_Q, OUT_OE, VERIFY_DATA, SIG_DATA;
   logic POR_DONE, PD_ACTIVE, FUSE_SET, VERIFY_VALID, VERIFY_DENIED;
   logic SIG_VALID, in_pd = 0, fuse = 0;
   logic [31:0] m_reg = 0, m_oe = 0, m_cmb = 0;
   int error_cnt = 0, compares = 0;
   initial forever #5 CLK = ~CLK;
   prs_ctrl #(.POR_CYC(POR), .SIG_VALUE(SIG)) i_dut (.CLK, .SYS_RST,
      .CFG_PD_EN, .POWER_DOWN_PIN, .IN_PINS, .OE_PINS, .REG_CLK_EN,
      .PRELOAD_HV, .PRELOAD_STB, .PRELOAD_SEL, .PRELOAD_VAL, .FUSE_PROG,
      .CFG_PATTERN, .VERIFY_REQ, .SIG_REQ, .SIG_SEL, .REG_Q, .COMB_Q,
      .OUT_OE, .POR_DONE, .PD_ACTIVE, .FUSE_SET, .VERIFY_VALID,
      .VERIFY_DENIED, .VERIFY_DATA, .SIG_VALID, .SIG_DATA);
   prs_sys_drv i_drv (.clk(CLK), .por_done(POR_DONE), .fire(fire),
      .slow(slow), .clk_en(REG_CLK_EN));
   task automatic conclude();
      if (error_cnt == 0 && compares > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task automatic chk(string n, logic [31:0] e, logic [31:0] g);
      compares++;
      if (g !== e) begin
         error_cnt++;
         $display("[FAIL] %s exp %h got %h", n, e, g);
      end
   endtask
   task automatic cyc(int n);
      repeat (n) @(posedge CLK);
   endtask
   task automatic rst();
      int n;
      SYS_RST <= 1;
      cyc(4);
      SYS_RST <= 0;
      for (n = 1; n < 40; n++) begin
         @(posedge CLK);
         #1;
         if (POR_DONE === 1'b1) break;
      end
      m_reg = 0;
      fuse = 0;
      chk("por_cycles", POR, n);
      chk("reg_clear", 0, REG_Q);
      chk("fuse_clear", 0, FUSE_SET);
   endtask
   task automatic cap(logic [31:0] d, logic pd);
      @(posedge CLK);
      IN_PINS <= d;
      OE_PINS <= ~d;
      CFG_PD_EN <= pd;
      cyc(3);
      fire <= 1;
      @(posedge CLK);
      fire <= 0;
      cyc(6);
      #1;
      if (!in_pd) begin
         m_reg = pd ? d & MSK : d;
         m_oe = ~d;
         m_cmb = m_reg ^ (pd ? d & MSK : d);
      end
      chk("reg_q", m_reg, REG_Q);
      chk("out_oe", m_oe, OUT_OE);
      chk("comb_q", m_cmb, COMB_Q);
   endtask
   task automatic pre(int s, logic v);
      @(posedge CLK);
      PRELOAD_HV <= 1;
      PRELOAD_STB <= 1;
      PRELOAD_SEL <= s[4:0];
      PRELOAD_VAL <= v;
      @(posedge CLK);
      PRELOAD_STB <= 0;
      PRELOAD_HV <= 0;
      cyc(3);
      #1;
      if (!in_pd && !fuse) m_reg[s] = v;
      chk("preload", m_reg, REG_Q);
   endtask
   task automatic ver(logic [31:0] p);
      @(posedge CLK);
      CFG_PATTERN <= p;
      VERIFY_REQ <= 1;
      @(posedge CLK);
      VERIFY_REQ <= 0;
      #1;
      chk("ver_valid", !fuse, VERIFY_VALID);
      chk("ver_deny", fuse, VERIFY_DENIED);
      chk("ver_data", fuse ? 0 : p, VERIFY_DATA);
   endtask
   task automatic sig(int k);
      @(posedge CLK);
      SIG_SEL <= k[2:0];
      SIG_REQ <= 1;
      @(posedge CLK);
      SIG_REQ <= 0;
      #1;
      chk("sig_valid", 1, SIG_VALID);
      chk("sig_data", k < 5 ? SIG[k*32 +: 32] : 0, SIG_DATA);
   endtask
   initial begin
      #300_000;
      error_cnt++;
      conclude();
   end
   initial begin
      void'($urandom(63));
      rst();
      cap($urandom, 0);
      @(posedge CLK);
      POWER_DOWN_PIN <= 1;
      cap($urandom, 0);
      chk("pd_off", 0, PD_ACTIVE);
      @(posedge CLK);
      POWER_DOWN_PIN <= 0;
      slow <= 1;
      cap($urandom, 1);
      slow <= 0;
      @(posedge CLK);
      POWER_DOWN_PIN <= 1;
      cyc(2);
      #1;
      chk("pd_on", 1, PD_ACTIVE);
      in_pd = 1;
      cap($urandom, 1);
      pre(3, !m_reg[3]);
      @(posedge CLK);
      POWER_DOWN_PIN <= 0;
      cyc(2);
      #1;
      in_pd = 0;
      chk("pd_exit", 0, PD_ACTIVE);
      chk("held", m_reg, REG_Q);
      cap($urandom, 1);
      for (int k = 0; k < 32; k += 3) pre(k, 1'($urandom));
      pre(31, 1);
      ver($urandom);
      for (int k = 0; k < 8; k++) sig(k);
      @(posedge CLK);
      FUSE_PROG <= 1;
      @(posedge CLK);
      FUSE_PROG <= 0;
      fuse = 1;
      ver($urandom);
      chk("fuse_set", 1, FUSE_SET);
      pre(5, !m_reg[5]);
      sig(2);
      @(posedge CLK);
      rst();
      conclude();
   end
endmodule
